// file: dv/engine_model.sv
// behavioural engine and generator seen from the sequencer outputs
// assumes the sequencer clock; fires only when will_start is high
`timescale 1ns/1ps

module engine_model
    import engine_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic will_start,
    input wire engine_seq_pkg::engine_out_type engine_out,
    output engine_seq_pkg::engine_in_type engine_in
);
    logic [3:0] crank_cnt;
    logic [3:0] vf_cnt;
    logic run_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crank_cnt <= 4'h0;
            vf_cnt <= 4'h0;
            run_q <= 1'b0;
        end
        else
        begin
            crank_cnt <= engine_out.crank ? crank_cnt + 4'h1 : 4'h0;
            // fires at the end of the fourth crank cycle, dies once fuel is cut
            if (engine_out.crank && will_start && crank_cnt == 4'h3)
                run_q <= 1'b1;
            else if (!engine_out.fuel)
                run_q <= 1'b0;
            vf_cnt <= !run_q ? 4'h0 : (vf_cnt == 4'hF ? vf_cnt : vf_cnt + 4'h1);
        end
    end

    always_comb
    begin
        engine_in.running = run_q;
        engine_in.volt_freq_ok = vf_cnt >= 4'h6;
        engine_in.coolant_temp = 8'h50;
        engine_in.supply_present = 4'hF;
        engine_in.generator_breaker_closed = engine_out.load_permit && !engine_out.generator_breaker_open;
    end
endmodule

// file: dv/engine_seq_monitor.sv
// port checker for the start/stop sequencer
// bound to every sequencer instance; one clock domain
`timescale 1ns/1ps

module engine_seq_monitor
    import engine_seq_pkg::*;
#(
    parameter int TICK_CYCLES = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire engine_seq_pkg::engine_in_type engine_in,
    input wire logic [engine_seq_pkg::REQ_SOURCES-1:0] start_request,
    input wire engine_seq_pkg::engine_out_type engine_out,
    input wire engine_seq_pkg::alarm_type alarms,
    input wire logic event_valid,
    input wire logic [7:0] event_code
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ======================================================================
    // assertions and cover points
    a_stop_fuel_apart: assert property (!(engine_out.stop && engine_out.fuel))
        else $error("stop and fuel outputs overlap");
    a_crank_ends_run: assert property (engine_out.crank && engine_in.running |-> ##[1:2] !engine_out.crank)
        else $error("crank kept on with engine running");
    a_stop_no_permit: assert property (engine_out.stop |-> !engine_out.ecu_permit_output)
        else $error("permit on during stop pulse");
    a_load_needs_vf: assert property (engine_out.load_permit |-> engine_out.min_vf_protection)
        else $error("load permit without min protections");
    a_prep_then_crank: assert property ($rose(engine_out.crank) |-> $past(engine_out.glow))
        else $error("crank without preheat before it");
    a_fail_start_quiet: assert property ($past(alarms.fail_start_alarm) |-> !engine_out.crank)
        else $error("crank after fail-start alarm");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_answer_next: assert property (psel && penable && !pready |=> pready)
        else $error("no answer in the cycle after access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");

    c_crank: cover property ($rose(engine_out.crank));
    c_load: cover property ($rose(engine_out.load_permit));
    c_fail_start: cover property ($rose(alarms.fail_start_alarm));
endmodule

bind engine_start_stop_sequencer engine_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .engine_in(engine_in), .start_request(start_request),
    .engine_out(engine_out), .alarms(alarms), .event_valid(event_valid), .event_code(event_code));

// file: dv/test_engine_start_stop_sequencer.sv
// self-checking bench for the start/stop sequencer
// engine_model on the engine side; seconds shortened to 4 clocks
`timescale 1ns/1ps

module test_engine_start_stop_sequencer;
    import engine_seq_pkg::*;
    localparam int TICK = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic will_start = 1'b0;
    logic [7:0] start_request = 8'h00;
    engine_in_type engine_in;
    engine_out_type engine_out;
    alarm_type alarms;
    logic event_valid;
    logic [7:0] event_code;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int cranks = 0;
    logic crank_d = 1'b0;
    logic seen_run = 1'b0;
    logic seen_req = 1'b0;
    logic [31:0] rd;
    logic err;
    int t0;
    int n;

    engine_start_stop_sequencer #(.TICK_CYCLES(TICK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .engine_in(engine_in), .start_request(start_request), .engine_out(engine_out),
        .alarms(alarms), .event_valid(event_valid), .event_code(event_code));
    engine_model partner (.pclk(pclk), .presetn(presetn), .will_start(will_start), .engine_out(engine_out),
        .engine_in(engine_in));

    always #12.5 pclk = ~pclk;

    always @(posedge pclk)
    begin
        cyc++;
        crank_d <= engine_out.crank;
        if (engine_out.crank === 1'b1 && crank_d === 1'b0)
            cranks++;
        if (event_valid === 1'b1 && event_code === 8'h42)
            seen_run <= 1'b1;
        if (event_valid === 1'b1 && event_code === 8'h81)
            seen_req <= 1'b1;
        if (cyc > 20000)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok)
        begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic regs_test();
        apb(1'b0, CRANK_OFS, 32'h0);
        chk(rd === CRANK_RST && err === 1'b0, "crank reset value");
        apb(1'b0, STOP_OFS, 32'h0);
        chk(rd === STOP_RST, "stop reset value");
        apb(1'b0, 8'hFC, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, CRANK_OFS, 32'h00010202);
        apb(1'b1, STEADY_OFS, 32'h01010205);
        apb(1'b1, STOP_OFS, 32'h04010103);
        apb(1'b1, AUX_OFS, 32'h00010000);
        apb(1'b0, STOP_OFS, 32'h0);
        chk(rd === 32'h04010103, "stop write readback");
    endtask

    task automatic fail_start_test();
        cranks = 0;
        will_start <= 1'b0;
        start_request <= 8'h02;
        n = 0;
        while (alarms.fail_start_alarm !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        chk(alarms.fail_start_alarm === 1'b1 && cranks == 2, "fail-start after two attempts");
        start_request <= 8'h00;
        repeat (40) @(posedge pclk);
        apb(1'b1, STATUS_OFS, 32'h7);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[2:0] === 3'b000, "alarm clear");
    endtask

    task automatic good_start_test();
        cranks = 0;
        will_start <= 1'b1;
        start_request <= 8'h02;
        n = 0;
        while (engine_out.min_vf_protection !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        t0 = cyc;
        while (engine_out.load_permit !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        chk(cyc - t0 >= 2 * TICK, "delivery delay skipped");
        chk(cranks == 1 && alarms.no_steady_alarm === 1'b0, "single attempt, steady");
        start_request <= 8'h00;
        while (engine_out.generator_breaker_open !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        t0 = cyc;
        while (engine_out.stop !== 1'b1 && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        chk(cyc - t0 >= 3 * TICK, "cooling run too short");
        chk(engine_out.ecu_permit_output === 1'b0 && engine_out.fuel === 1'b0, "stop outputs");
        repeat (40) @(posedge pclk);
        chk(engine_in.running === 1'b0 && alarms.fail_stop_alarm === 1'b0, "engine stopped cleanly");
        chk(seen_run === 1'b1, "running event missing");
        chk(seen_req === 1'b1, "automatic request event missing");
    endtask

    task automatic manual_test();
        apb(1'b1, CTRL_OFS, 32'h3);
        start_request <= 8'h01;
        while (engine_out.low_speed !== 1'b1)
            @(posedge pclk);
        t0 = cyc;
        while (engine_out.min_vf_protection !== 1'b1)
            @(posedge pclk);
        chk(cyc - t0 >= TICK, "low speed short");
        chk(engine_out.load_permit === 1'b1, "manual delay");
        start_request <= 8'h00;
        while (engine_out.stop !== 1'b1)
            @(posedge pclk);
        chk(cyc - t0 < 5 * TICK, "manual cooled");
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        regs_test();
        fail_start_test();
        good_start_test();
        manual_test();
        stop_test();
    end
endmodule

// file: verilog/engine_seq_pkg.sv
// engine start/stop sequencer: register map, field layout, reset values, states, carriers
// assumes a 40 MHz pclk and an APB master with 32-bit data
package engine_seq_pkg;

    // ======================================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ======================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] EVT_EN_OFS = 8'h04;
    localparam logic [7:0] CRANK_OFS = 8'h08;
    localparam logic [7:0] STEADY_OFS = 8'h0C;
    localparam logic [7:0] STOP_OFS = 8'h10;
    localparam logic [7:0] AUX_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] EVENT_OFS = 8'h1C;

    // ======================================================================
    // field positions
    localparam int CTRL_MANUAL_BIT = 0;
    localparam int CTRL_LOW_SPEED_BIT = 1;
    localparam int CTRL_DUAL_BATT_BIT = 2;
    localparam int CTRL_ESTOP_BIT = 3;
    localparam int EVT_ENGINE_BIT = 3;
    localparam int EVT_REQUEST_BIT = 6;
    // byte lanes of the configuration registers, and the bit position of the supply selector
    localparam int CRANK_ATTEMPTS_B = 0;
    localparam int CRANK_TIME_B = 1;
    localparam int CRANK_PAUSE_B = 2;
    localparam int CRANK_BATT_EXTRA_B = 3;
    localparam int STEADY_TIMEOUT_B = 0;
    localparam int STEADY_DELIVERY_B = 1;
    localparam int STEADY_OIL_MASK_B = 2;
    localparam int STEADY_LOW_SPEED_B = 3;
    localparam int STOP_COOL_B = 0;
    localparam int STOP_FUEL_DELAY_B = 1;
    localparam int STOP_PULSE_B = 2;
    localparam int STOP_CYCLE_B = 3;
    localparam int AUX_SRC_LSB = 0;
    localparam int AUX_COOL_THR_B = 1;
    localparam int AUX_PREP_B = 2;

    // ======================================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EVT_EN_RST = 8'h48;
    localparam logic [31:0] CRANK_RST = 32'h050A0503;
    localparam logic [31:0] STEADY_RST = 32'h0A0A050A;
    localparam logic [31:0] STOP_RST = 32'h1E0A023C;
    localparam logic [31:0] AUX_RST = 32'h00030000;

    // ======================================================================
    // services supply selector and event codes
    localparam logic [1:0] SRC_GENERATOR = 2'h0;
    localparam logic [1:0] SRC_PARALLEL_BARS = 2'h1;
    localparam logic [1:0] SRC_USER_SIDE = 2'h2;
    localparam logic [1:0] SRC_MAINS = 2'h3;
    localparam logic [7:0] EV_ENGINE_BASE = 8'h40;
    localparam logic [7:0] EV_REQUEST_BASE = 8'h80;
    localparam int REQ_SOURCES = 8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PREP = 4'h1,
        ST_CRANK = 4'h2,
        ST_PAUSE = 4'h3,
        ST_LOW_SPEED = 4'h4,
        ST_STEADY = 4'h5,
        ST_WARMUP = 4'h6,
        ST_RUN = 4'h7,
        ST_BREAKER_OPEN = 4'h8,
        ST_COOL = 4'h9,
        ST_STOP = 4'hA
    } phase_type;

    typedef struct packed {
        logic running;
        logic volt_freq_ok;
        logic [7:0] coolant_temp;
        logic [3:0] supply_present;
        logic generator_breaker_closed;
    } engine_in_type;

    typedef struct packed {
        logic crank;
        logic fuel;
        logic stop;
        logic ecu_permit_output;
        logic prelube;
        logic glow;
        logic cleaning;
        logic generator_breaker_open;
        logic battery_sel;
        logic low_speed;
        logic load_permit;
        logic min_vf_protection;
        logic oil_protection;
    } engine_out_type;

    typedef struct packed {
        logic fail_start_alarm;
        logic no_steady_alarm;
        logic fail_stop_alarm;
    } alarm_type;

endpackage

// file: verilog/engine_start_stop_sequencer.sv
// engine start/stop sequencer with APB register slave and event logger
// assumes synchronous engine inputs and request sources on pclk
`timescale 1ns/1ps

module engine_start_stop_sequencer
    import engine_seq_pkg::*;
#(
    parameter int TICK_CYCLES = engine_seq_pkg::TICK_CYCLES_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire engine_seq_pkg::engine_in_type engine_in,
    input wire logic [engine_seq_pkg::REQ_SOURCES-1:0] start_request,
    output engine_seq_pkg::engine_out_type engine_out,
    output engine_seq_pkg::alarm_type alarms,
    output logic event_valid,
    output logic [7:0] event_code
);

    import engine_seq_pkg::*;

    if (TICK_CYCLES < 2)
    begin : g_tick_check
        $error("TICK_CYCLES must be at least 2");
    end

    // ======================================================================
    // state
    typedef struct packed {
        phase_type phase;
        logic [31:0] tick_cnt;
        logic [7:0] sec;
        logic [7:0] attempt;
        logic long_pause;
        logic cooling_due;
        logic oil_masking;
        logic [7:0] oil_sec;
        logic [7:0] ctrl;
        logic [7:0] evt_en;
        logic [31:0] crank_cfg;
        logic [31:0] steady_cfg;
        logic [31:0] stop_cfg;
        logic [31:0] aux_cfg;
        logic [REQ_SOURCES-1:0] req_prev;
        logic [15:0] event_count;
        logic ev_valid;
        logic [7:0] ev_code;
        engine_out_type eo;
        alarm_type al;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } seq_state_type;

    seq_state_type r_q;
    seq_state_type r_d;

    function automatic logic [7:0] field_byte(input logic [31:0] word, input int lane);
        field_byte = word[lane*8 +: 8];
    endfunction

    // engine state class seen by the event log
    function automatic logic [2:0] engine_class(input phase_type p);
        unique case (p)
            ST_IDLE: engine_class = 3'h0;
            ST_PREP, ST_CRANK, ST_PAUSE, ST_STEADY: engine_class = 3'h1;
            ST_WARMUP, ST_RUN, ST_BREAKER_OPEN: engine_class = 3'h2;
            ST_COOL: engine_class = 3'h3;
            ST_STOP: engine_class = 3'h4;
            ST_LOW_SPEED: engine_class = 3'h5;
        endcase
    endfunction

    // ======================================================================
    // next state
    logic tick;
    logic start_ok;
    logic estop;
    logic manual;
    logic attempt_over;
    logic wr_access;
    logic rd_access;
    logic [7:0] attempts_cfg;
    logic [7:0] fuel_delay;
    logic [8:0] stop_end;
    logic [1:0] src;
    logic [7:0] cool_thr;
    logic [REQ_SOURCES-1:0] req_diff;
    logic req_found;

    always_comb
    begin
        r_d = r_q;
        req_found = 1'b0;
        manual = r_q.ctrl[CTRL_MANUAL_BIT];
        estop = r_q.ctrl[CTRL_ESTOP_BIT];
        attempts_cfg = field_byte(r_q.crank_cfg, CRANK_ATTEMPTS_B);
        fuel_delay = field_byte(r_q.stop_cfg, STOP_FUEL_DELAY_B);
        stop_end = 9'(fuel_delay) + 9'(field_byte(r_q.stop_cfg, STOP_PULSE_B));
        src = r_q.aux_cfg[AUX_SRC_LSB +: 2];
        cool_thr = field_byte(r_q.aux_cfg, AUX_COOL_THR_B);
        attempt_over = 1'b0;

        // one-second tick
        tick = r_q.tick_cnt == 32'(TICK_CYCLES - 1);
        r_d.tick_cnt = tick ? 32'h00000000 : r_q.tick_cnt + 32'h00000001;
        if (tick && r_q.sec != 8'hFF)
        begin
            r_d.sec = r_q.sec + 8'h01;
        end

        // APB slave, one wait state
        wr_access = psel && penable && !r_q.ready && pwrite;
        rd_access = psel && penable && !r_q.ready && !pwrite;
        r_d.ready = psel && penable && !r_q.ready;
        r_d.slverr = 1'b0;
        r_d.rdata = 32'h00000000;
        if (wr_access)
        begin
            unique case (paddr)
                CTRL_OFS: r_d.ctrl = pwdata[7:0];
                EVT_EN_OFS: r_d.evt_en = pwdata[7:0];
                CRANK_OFS: r_d.crank_cfg = pwdata;
                STEADY_OFS: r_d.steady_cfg = pwdata;
                STOP_OFS: r_d.stop_cfg = pwdata;
                AUX_OFS: r_d.aux_cfg = pwdata;
                STATUS_OFS: r_d.al = r_q.al & ~alarm_type'(pwdata[2:0]);
                EVENT_OFS: r_d.slverr = 1'b0;
                default: r_d.slverr = 1'b1;
            endcase
        end
        if (rd_access)
        begin
            unique case (paddr)
                CTRL_OFS: r_d.rdata = {24'h000000, r_q.ctrl};
                EVT_EN_OFS: r_d.rdata = {24'h000000, r_q.evt_en};
                CRANK_OFS: r_d.rdata = r_q.crank_cfg;
                STEADY_OFS: r_d.rdata = r_q.steady_cfg;
                STOP_OFS: r_d.rdata = r_q.stop_cfg;
                AUX_OFS: r_d.rdata = r_q.aux_cfg;
                STATUS_OFS: r_d.rdata = {r_q.attempt, 8'h00, r_q.eo.oil_protection,
                    r_q.eo.min_vf_protection, r_q.eo.battery_sel, 1'b0, 4'(r_q.phase),
                    5'h00, r_q.al};
                EVENT_OFS: r_d.rdata = {r_q.event_count, 8'h00, r_q.ev_code};
                default: r_d.slverr = 1'b1;
            endcase
        end

        start_ok = (manual ? start_request[0] : |start_request[REQ_SOURCES-1:1])
            && !estop && (r_q.al == 3'h0);

        // ==================================================================
        // sequencer
        unique case (r_q.phase)
            ST_IDLE:
            begin
                r_d.eo.min_vf_protection = 1'b0;
                if (start_ok)
                begin
                    r_d.phase = ST_PREP;
                    r_d.attempt = 8'h00;
                    r_d.eo.battery_sel = 1'b0;
                    r_d.cooling_due = 1'b0;
                end
            end
            ST_PREP:
            begin
                if (!start_ok)
                    r_d.phase = ST_STOP;
                else if (r_q.sec >= field_byte(r_q.aux_cfg, AUX_PREP_B))
                    r_d.phase = ST_CRANK;
            end
            ST_CRANK:
            begin
                if (!start_ok)
                    r_d.phase = ST_STOP;
                else if (engine_in.running)
                begin
                    r_d.attempt = r_q.attempt + 8'h01;
                    r_d.oil_masking = 1'b1;
                    r_d.oil_sec = 8'h00;
                    r_d.phase = r_q.ctrl[CTRL_LOW_SPEED_BIT] ? ST_LOW_SPEED : ST_STEADY;
                end
                else if (r_q.sec >= field_byte(r_q.crank_cfg, CRANK_TIME_B))
                begin
                    r_d.attempt = r_q.attempt + 8'h01;
                    attempt_over = 1'b1;
                end
            end
            ST_PAUSE:
            begin
                if (!start_ok)
                    r_d.phase = ST_STOP;
                else if (9'(r_q.sec) >= 9'(field_byte(r_q.crank_cfg, CRANK_PAUSE_B))
                    + (r_q.long_pause ? 9'(field_byte(r_q.crank_cfg, CRANK_BATT_EXTRA_B)) : 9'h000))
                    r_d.phase = ST_PREP;
            end
            ST_LOW_SPEED:
            begin
                if (!start_ok || estop)
                    r_d.phase = ST_STOP;
                else if (!engine_in.running)
                    attempt_over = 1'b1;
                else if (r_q.sec >= field_byte(r_q.steady_cfg, STEADY_LOW_SPEED_B))
                    r_d.phase = ST_STEADY;
            end
            ST_STEADY:
            begin
                if (!start_ok || estop)
                    r_d.phase = ST_STOP;
                else if (!engine_in.running)
                    attempt_over = 1'b1;
                else if (engine_in.volt_freq_ok)
                begin
                    r_d.eo.min_vf_protection = 1'b1;
                    r_d.phase = manual ? ST_RUN : ST_WARMUP;
                end
                else if (r_q.sec >= field_byte(r_q.steady_cfg, STEADY_TIMEOUT_B))
                begin
                    r_d.al.no_steady_alarm = 1'b1;
                    r_d.phase = ST_STOP;
                end
            end
            ST_WARMUP:
            begin
                if (estop)
                    r_d.phase = ST_STOP;
                else if (!start_ok)
                    r_d.phase = ST_BREAKER_OPEN;
                else if (r_q.sec >= field_byte(r_q.steady_cfg, STEADY_DELIVERY_B))
                    r_d.phase = ST_RUN;
            end
            ST_RUN:
            begin
                if (engine_in.generator_breaker_closed && !manual)
                    r_d.cooling_due = 1'b1;
                if (estop)
                    r_d.phase = ST_STOP;
                else if (!start_ok)
                    r_d.phase = ST_BREAKER_OPEN;
            end
            ST_BREAKER_OPEN:
            begin
                // open command issued this cycle; stop sequence follows
                r_d.phase = r_q.cooling_due && !estop ? ST_COOL : ST_STOP;
            end
            ST_COOL:
            begin
                if (estop || r_q.sec >= field_byte(r_q.stop_cfg, STOP_COOL_B))
                    r_d.phase = ST_STOP;
                else if (cool_thr != 8'h00 && engine_in.coolant_temp < cool_thr)
                    r_d.phase = ST_STOP;
                else if (!engine_in.supply_present[src])
                    r_d.phase = ST_STOP;
                else if (start_ok)
                    r_d.phase = ST_RUN;
            end
            ST_STOP:
            begin
                r_d.eo.min_vf_protection = 1'b0;
                if (r_q.sec >= field_byte(r_q.stop_cfg, STOP_CYCLE_B))
                begin
                    if (engine_in.running)
                        r_d.al.fail_stop_alarm = 1'b1;
                    r_d.phase = ST_IDLE;
                end
                else if (start_ok && !engine_in.running && !r_q.eo.fuel && r_q.sec > fuel_delay)
                    r_d.phase = ST_IDLE;
            end
            default:
                r_d.phase = ST_IDLE;
        endcase

        // attempt ended without a start
        if (attempt_over)
        begin
            r_d.long_pause = 1'b0;
            if (r_d.attempt < attempts_cfg)
                r_d.phase = ST_PAUSE;
            else if (r_q.ctrl[CTRL_DUAL_BATT_BIT] && !r_q.eo.battery_sel && !manual)
            begin
                r_d.eo.battery_sel = 1'b1;
                r_d.attempt = 8'h00;
                r_d.long_pause = 1'b1;
                r_d.phase = ST_PAUSE;
            end
            else
            begin
                r_d.al.fail_start_alarm = 1'b1;
                r_d.phase = ST_STOP;
            end
        end

        // phase timers restart at entry
        if (r_d.phase != r_q.phase)
        begin
            r_d.tick_cnt = 32'h00000000;
            r_d.sec = 8'h00;
        end

        // oil protection mask runs across phases
        if (r_q.oil_masking && tick)
            r_d.oil_sec = r_q.oil_sec + 8'h01;
        if (r_d.oil_sec >= field_byte(r_q.steady_cfg, STEADY_OIL_MASK_B))
            r_d.oil_masking = 1'b0;

        // ==================================================================
        // outputs from next phase
        r_d.eo.crank = r_d.phase == ST_CRANK;
        r_d.eo.prelube = r_d.phase == ST_PREP;
        r_d.eo.glow = r_d.phase == ST_PREP;
        r_d.eo.cleaning = r_d.phase == ST_PAUSE;
        r_d.eo.low_speed = r_d.phase == ST_LOW_SPEED;
        r_d.eo.load_permit = r_d.phase == ST_RUN;
        r_d.eo.generator_breaker_open = r_d.phase inside {ST_BREAKER_OPEN, ST_COOL, ST_STOP};
        r_d.eo.ecu_permit_output = r_d.phase inside {ST_CRANK, ST_LOW_SPEED, ST_STEADY,
            ST_WARMUP, ST_RUN, ST_BREAKER_OPEN, ST_COOL};
        // fuel held until the release delay; stop pulse only after it
        r_d.eo.fuel = r_d.eo.ecu_permit_output || (r_d.phase == ST_STOP && r_d.sec < fuel_delay);
        r_d.eo.stop = r_d.phase == ST_STOP && !r_d.eo.fuel && 9'(r_d.sec) < stop_end;
        r_d.eo.oil_protection = !r_d.oil_masking && r_d.phase inside {ST_LOW_SPEED, ST_STEADY,
            ST_WARMUP, ST_RUN, ST_BREAKER_OPEN, ST_COOL};
        if (r_d.phase == ST_IDLE)
            r_d.oil_masking = 1'b0;

        // ==================================================================
        // event log, engine class first, one request change per cycle
        r_d.ev_valid = 1'b0;
        req_diff = start_request ^ r_q.req_prev;
        if (!r_q.evt_en[EVT_REQUEST_BIT])
            r_d.req_prev = start_request;
        if (r_q.evt_en[EVT_ENGINE_BIT] && engine_class(r_d.phase) != engine_class(r_q.phase))
        begin
            r_d.ev_valid = 1'b1;
            r_d.ev_code = EV_ENGINE_BASE | 8'(engine_class(r_d.phase));
        end
        else if (r_q.evt_en[EVT_REQUEST_BIT])
        begin
            for (int i = 0; i < REQ_SOURCES; i++)
            begin
                if (req_diff[i] && !req_found)
                begin
                    req_found = 1'b1;
                    r_d.req_prev[i] = start_request[i];
                    r_d.ev_valid = 1'b1;
                    r_d.ev_code = EV_REQUEST_BASE | {4'h0, !start_request[i], 3'(i)};
                end
            end
        end
        if (r_d.ev_valid)
            r_d.event_count = r_q.event_count + 16'h0001;
    end

    // ======================================================================
    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q <= '0;
            r_q.phase <= ST_IDLE;
            r_q.ctrl <= CTRL_RST;
            r_q.evt_en <= EVT_EN_RST;
            r_q.crank_cfg <= CRANK_RST;
            r_q.steady_cfg <= STEADY_RST;
            r_q.stop_cfg <= STOP_RST;
            r_q.aux_cfg <= AUX_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign prdata = r_q.rdata;
    assign pready = r_q.ready;
    assign pslverr = r_q.slverr;
    assign engine_out = r_q.eo;
    assign alarms = r_q.al;
    assign event_valid = r_q.ev_valid;
    assign event_code = r_q.ev_code;

endmodule
